// *** shared/atl_pkg.sv ***
package atl_pkg;
  // Conversion and table geometry
  localparam int CODE_W = 8;
  localparam int IDX_W = 5;
  localparam int WGT_W = 3;
  localparam int TBL_DEPTH = 33;
  localparam int TBL_AW = 6;
  localparam logic [4:0] IDX_MASK = 5'h1f;
  localparam logic [2:0] WGT_MASK = 3'h7;
  localparam int IDX_SHIFT = 3;
  localparam int WGT_DIV = 8;
  // Gain codes
  localparam logic [1:0] GAIN_MIN = 2'h0;
  localparam logic [1:0] GAIN_MAX = 2'h3;
  localparam int GAIN_BIT_POS = 3;
  localparam logic [1:0] GAIN_RST = 2'h0;
  // Settling time
  localparam int CLK_MHZ = 100;
  localparam int SETTLE_US = 20;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int RETRY_MAX = 1;
  // APB map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_PIN_HI = 8'h0c;
  localparam logic [7:0] ADDR_PIN_LO = 8'h10;
  localparam logic [7:0] ADDR_TBL_IDX = 8'h14;
  localparam logic [7:0] ADDR_TBL_DATA = 8'h18;
  localparam int CTRL_START_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  // APB request carrier
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } atl_apb_req_t;

  // Result carrier: value and gain range
  typedef struct packed {
    logic [1:0] gain;
    logic [7:0] raw;
    logic [7:0] value;
  } atl_result_t;
endpackage

// *** core/atl_table_mem.sv ***
`timescale 1ns/1ps
// Table storage with registered read data
module atl_table_mem #(
  parameter int DEPTH = 33,
  parameter int AW = 6
) (
  input wire logic CLOCK,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];

  initial
  begin
    if (DEPTH > (1 << AW))
    begin
      $error("Table depth exceeds address width");
    end
  end

  // Write port
  always_ff @(posedge CLOCK)
  begin
    if (we && (32'(waddr) < DEPTH))
    begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read; out of range reads as zero
  always_ff @(posedge CLOCK)
  begin
    if (32'(raddr) < DEPTH)
    begin
      rdata <= mem[raddr];
    end
    else
    begin
      rdata <= 8'h00;
    end
  end
endmodule

// *** core/atl_linearizer.sv ***
`timescale 1ns/1ps
module atl_linearizer #(
  parameter int SETTLE_CYCLES = atl_pkg::SETTLE_CYC
) (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RANGE_COMPARE_IN_A,
  input wire logic RANGE_COMPARE_IN_B,
  output logic CONV_START,
  input wire logic CONV_DONE,
  input wire logic [7:0] CONV_DATA,
  output logic GAIN_SELECT_HIGH_PIN,
  output logic GAIN_SELECT_LOW_PIN,
  output logic [17:0] RESULT_OUT,
  output logic RESULT_VALID
);
  initial
  begin
    if (SETTLE_CYCLES < 1)
    begin
      $error("Settle count must be at least one");
    end
  end

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_CHECK = 8'h02,
    ST_SETTLE = 8'h04,
    ST_CONV = 8'h08,
    ST_WAIT = 8'h10,
    ST_RD0 = 8'h20,
    ST_RD1 = 8'h40,
    ST_CALC = 8'h80
  } atl_state_t;

  atl_state_t state_ff;
  atl_state_t nxt_state;
  atl_pkg::atl_apb_req_t req;
  atl_pkg::atl_result_t result_ff;
  logic [7:0] pin_hi_ff;
  logic [7:0] pin_lo_ff;
  logic [5:0] tbl_idx_ff;
  logic [7:0] code_ff;
  logic [7:0] entry_ff;
  logic [7:0] tbl_rdata;
  logic [5:0] tbl_raddr;
  logic retry_ff;
  logic done_ff;
  logic start_ff;
  logic valid_ff;
  logic [31:0] settle_ff;
  logic below;
  logic above;
  logic wr_acc;
  logic tbl_we;
  logic [1:0] gain_now;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Index field of a code
  function automatic logic [4:0] idx_of(input logic [7:0] c);
    idx_of = 5'(c >> atl_pkg::IDX_SHIFT) & atl_pkg::IDX_MASK;
  endfunction

  // Weight field of a code
  function automatic logic [2:0] wgt_of(input logic [7:0] c);
    wgt_of = c[2:0] & atl_pkg::WGT_MASK;
  endfunction

  assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};
  assign wr_acc = req.sel && req.enable && req.write;
  assign tbl_we = wr_acc && (req.addr == atl_pkg::ADDR_TBL_DATA);
  // Comparator a low means below lower trip, b high means above upper
  assign below = !RANGE_COMPARE_IN_A;
  assign above = RANGE_COMPARE_IN_B;

  ////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states

  assign PREADY = 1'b1;

  // Unmapped addresses report an error
  always_comb
  begin
    case (req.addr)
      atl_pkg::ADDR_CTRL, atl_pkg::ADDR_STATUS, atl_pkg::ADDR_RESULT,
      atl_pkg::ADDR_PIN_HI, atl_pkg::ADDR_PIN_LO, atl_pkg::ADDR_TBL_IDX,
      atl_pkg::ADDR_TBL_DATA: PSLVERR = 1'b0;
      default: PSLVERR = req.sel && req.enable;
    endcase
  end

  // Read mux; table data is not readable to keep the read port for math
  always_comb
  begin
    PRDATA = 32'h0000_0000;
    case (req.addr)
      atl_pkg::ADDR_STATUS: PRDATA = {30'h0, done_ff, state_ff != ST_IDLE};
      atl_pkg::ADDR_RESULT: PRDATA = {14'h0, result_ff};
      atl_pkg::ADDR_PIN_HI: PRDATA = {24'h0, pin_hi_ff};
      atl_pkg::ADDR_PIN_LO: PRDATA = {24'h0, pin_lo_ff};
      atl_pkg::ADDR_TBL_IDX: PRDATA = {26'h0, tbl_idx_ff};
      default: PRDATA = 32'h0000_0000;
    endcase
  end

  // Table index auto-increments after each data write for easy loading
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      tbl_idx_ff <= 6'h00;
    end
    else if (wr_acc && req.addr == atl_pkg::ADDR_TBL_IDX)
    begin
      tbl_idx_ff <= req.wdata[5:0];
    end
    else if (tbl_we)
    begin
      tbl_idx_ff <= tbl_idx_ff + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Table storage, 33 entries

  assign tbl_raddr = (state_ff == ST_RD0) ? {1'b0, idx_of(code_ff)}
                                          : 6'({1'b0, idx_of(code_ff)} + 6'h01);

  atl_table_mem #(
    .DEPTH(atl_pkg::TBL_DEPTH),
    .AW(atl_pkg::TBL_AW)
  ) u_table (
    .CLOCK(CLOCK),
    .we(tbl_we),
    .waddr(tbl_idx_ff),
    .wdata(req.wdata[7:0]),
    .raddr(tbl_raddr),
    .rdata(tbl_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (wr_acc && req.addr == atl_pkg::ADDR_CTRL && req.wdata[atl_pkg::CTRL_START_BIT])
          nxt_state = ST_CHECK;
      ST_CHECK:
      begin
        // Gain change only if one is possible and a retry remains
        if (!retry_ff && ((below && gain_now != atl_pkg::GAIN_MAX) ||
                          (above && gain_now != atl_pkg::GAIN_MIN)))
          nxt_state = ST_SETTLE;
        else
          nxt_state = ST_CONV;
      end
      ST_SETTLE:
        if (settle_ff == 32'd1)
          nxt_state = ST_CHECK;
      ST_CONV: nxt_state = ST_WAIT;
      ST_WAIT:
        if (CONV_DONE)
          nxt_state = ST_RD0;
      ST_RD0: nxt_state = ST_RD1;
      ST_RD1: nxt_state = ST_CALC;
      ST_CALC: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_ff <= ST_IDLE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // One recheck only per measurement
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      retry_ff <= 1'b0;
    end
    else if (state_ff == ST_IDLE)
    begin
      retry_ff <= 1'b0;
    end
    else if (state_ff == ST_CHECK && nxt_state == ST_SETTLE)
    begin
      retry_ff <= 1'b1;
    end
  end

  // Settle counter loaded on every gain change made by the range check; pin register writes do not load it
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      settle_ff <= 32'd0;
    end
    else if (state_ff == ST_CHECK && nxt_state == ST_SETTLE)
    begin
      settle_ff <= 32'(SETTLE_CYCLES);
    end
    else if (settle_ff != 32'd0)
    begin
      settle_ff <= settle_ff - 32'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Gain control and pin control registers

  // Gain lives in bit 3 of both pin registers; software may also write them
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pin_hi_ff <= 8'h00;
      pin_lo_ff <= 8'h00;
    end
    else if (state_ff == ST_CHECK && nxt_state == ST_SETTLE)
    begin
      // Below lower trip raises, above upper lowers
      if (below)
      begin
        {pin_hi_ff[atl_pkg::GAIN_BIT_POS], pin_lo_ff[atl_pkg::GAIN_BIT_POS]} <=
          gain_now + 2'h1;
      end
      else
      begin
        {pin_hi_ff[atl_pkg::GAIN_BIT_POS], pin_lo_ff[atl_pkg::GAIN_BIT_POS]} <=
          gain_now - 2'h1;
      end
    end
    else if (wr_acc && req.addr == atl_pkg::ADDR_PIN_HI)
    begin
      pin_hi_ff <= req.wdata[7:0];
    end
    else if (wr_acc && req.addr == atl_pkg::ADDR_PIN_LO)
    begin
      pin_lo_ff <= req.wdata[7:0];
    end
  end

  // Pins follow bit 3; codes 00..11 select gain 1, 2, 4, 8
  assign GAIN_SELECT_HIGH_PIN = pin_hi_ff[atl_pkg::GAIN_BIT_POS];
  assign GAIN_SELECT_LOW_PIN = pin_lo_ff[atl_pkg::GAIN_BIT_POS];
  // Live gain code; the result copy lags a clock, so decisions use this
  assign gain_now = {pin_hi_ff[atl_pkg::GAIN_BIT_POS], pin_lo_ff[atl_pkg::GAIN_BIT_POS]};

  ////////////////////////////////////////////////////////////////////////
  // Conversion and interpolation

  // Start pulse and captured code
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      start_ff <= 1'b0;
      code_ff <= 8'h00;
    end
    else
    begin
      start_ff <= (state_ff == ST_CHECK) && (nxt_state == ST_CONV);
      if (state_ff == ST_WAIT && CONV_DONE)
      begin
        code_ff <= CONV_DATA;
      end
    end
  end

  assign CONV_START = start_ff;

  // First fetched entry F(I)
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      entry_ff <= 8'h00;
    end
    else if (state_ff == ST_RD1)
    begin
      entry_ff <= tbl_rdata;
    end
  end

  // Signed difference, weighted, divided by 8 truncating toward zero
  // Operands widened before the multiply: 7 x 255 overflows nine bits
  logic signed [8:0] diff;
  logic signed [12:0] prod;
  logic [7:0] interp;
  assign diff = $signed({1'b0, tbl_rdata}) - $signed({1'b0, entry_ff});
  assign prod = 13'(diff) * 13'($signed({1'b0, wgt_of(code_ff)}));
  assign interp = 8'($signed({1'b0, entry_ff}) + 13'(prod / atl_pkg::WGT_DIV));

  // Result register holds value, raw code and gain range
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      result_ff <= '0;
      done_ff <= 1'b0;
      valid_ff <= 1'b0;
    end
    else
    begin
      valid_ff <= (state_ff == ST_CALC);
      result_ff.gain <= gain_now;
      if (state_ff == ST_CALC)
      begin
        result_ff.raw <= code_ff;
        if (wgt_of(code_ff) == 3'h0)
        begin
          result_ff.value <= entry_ff;
        end
        else
        begin
          result_ff.value <= interp;
        end
      end
      // Completion wins over a simultaneous clear
      if (state_ff == ST_CALC)
      begin
        done_ff <= 1'b1;
      end
      else if (wr_acc && req.addr == atl_pkg::ADDR_STATUS && req.wdata[atl_pkg::STAT_DONE_BIT])
      begin
        done_ff <= 1'b0;
      end
    end
  end

  assign RESULT_OUT = result_ff;
  assign RESULT_VALID = valid_ff;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence gain_move_s;
    state_ff == ST_CHECK && nxt_state == ST_SETTLE;
  endsequence

  raise_gain_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    gain_move_s and below |=> gain_now == $past(gain_now) + 2'h1)
    else $error("gain not raised when below range");

  lower_gain_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    gain_move_s and !below |=> gain_now == $past(gain_now) - 2'h1)
    else $error("gain not lowered when above range");

  gain_cap_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    state_ff == ST_CHECK && below && gain_now == atl_pkg::GAIN_MAX |-> nxt_state != ST_SETTLE)
    else $error("gain raised past maximum");

  settle_wait_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    gain_move_s |=> settle_ff == 32'(SETTLE_CYCLES) && state_ff == ST_SETTLE)
    else $error("settle wait not started");

  one_retry_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    state_ff == ST_CHECK && retry_ff |-> nxt_state == ST_CONV)
    else $error("more than one range retry");

  pin_map_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    !(state_ff == ST_CHECK && nxt_state == ST_SETTLE) &&
    !(wr_acc && (req.addr == atl_pkg::ADDR_PIN_HI || req.addr == atl_pkg::ADDR_PIN_LO))
    |=> $stable({GAIN_SELECT_HIGH_PIN, GAIN_SELECT_LOW_PIN}))
    else $error("gain pins moved without a cause");

  no_interp_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    state_ff == ST_CALC && code_ff[2:0] == 3'h0 |=> result_ff.value == $past(entry_ff))
    else $error("zero weight result not table entry");

  start_conv_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    state_ff == ST_CHECK ##1 state_ff == ST_CONV |-> CONV_START)
    else $error("conversion not started after range check");

  gain_tag_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    state_ff == ST_CALC |=> RESULT_VALID && result_ff.raw == $past(code_ff) &&
    result_ff.gain == $past(gain_now))
    else $error("result not stored with code");
endmodule

// *** sim/atl_front_model.sv ***
`timescale 1ns/1ps
// Converter, trip comparators and gain-switched amplifier behind the block
module atl_front_model #(
  parameter int LO_TRIP = 64,
  parameter int HI_TRIP = 200
) (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic conv_start,
  input wire logic gain_hi,
  input wire logic gain_lo,
  input wire logic [7:0] level,
  input wire logic [3:0] dly,
  output logic cmp_a,
  output logic cmp_b,
  output logic conv_done,
  output logic [7:0] conv_data
);
  int amp;
  int cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Amplified level follows the gain pins at once; settling is the block's job
  always_comb amp = int'(level) << {gain_hi, gain_lo};
  assign cmp_a = !(amp < LO_TRIP); // Low while below the lower trip
  assign cmp_b = amp > HI_TRIP;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion answer after a chosen delay; data scrambled outside the pulse
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      cnt <= 0;
      conv_done <= 1'b0;
      conv_data <= 8'h00;
    end
    else
    begin
      conv_done <= 1'b0;
      if (conv_start)
        cnt <= int'(dly);
      else if (cnt > 0)
        cnt <= cnt - 1;
      if (cnt == 1)
      begin
        conv_done <= 1'b1;
        conv_data <= (amp > 255) ? 8'hff : amp[7:0]; // Converter clips at full scale
      end
      else
        conv_data <= ~conv_data; // No stale value lingers on the bus
    end
  end
endmodule

// *** sim/atl_linearizer_bench.sv ***
`timescale 1ns/1ps
module atl_linearizer_bench;
  logic CLOCK, RST_B, psel, penable, pwrite, pready, pslverr;
  logic conv_start, conv_done, valid, cmp_a, cmp_b, g_hi, g_lo;
  logic [7:0] paddr, conv_data, level;
  logic [31:0] pwdata, prdata;
  logic [17:0] res;
  logic [3:0] dly;
  logic [7:0] tbl [0:32];
  int bad_count, compares, cycles;

  atl_linearizer #(.SETTLE_CYCLES(5)) atl_linearizer_inst (.CLOCK(CLOCK), .RST_B(RST_B),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RANGE_COMPARE_IN_A(cmp_a),
    .RANGE_COMPARE_IN_B(cmp_b), .CONV_START(conv_start), .CONV_DONE(conv_done),
    .CONV_DATA(conv_data), .GAIN_SELECT_HIGH_PIN(g_hi), .GAIN_SELECT_LOW_PIN(g_lo),
    .RESULT_OUT(res), .RESULT_VALID(valid));
  atl_front_model atl_front_model_inst (.CLOCK(CLOCK), .RST_B(RST_B), .conv_start(conv_start),
    .gain_hi(g_hi), .gain_lo(g_lo), .level(level), .dly(dly), .cmp_a(cmp_a), .cmp_b(cmp_b),
    .conv_done(conv_done), .conv_data(conv_data));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; a few hundred cycles are needed, so 5000 is ample
  initial
  begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  initial
  begin
    cycles = 0;
    forever
    begin
      @(posedge CLOCK);
      cycles++;
      if (cycles >= 5000)
      begin
        bad_count++;
        results;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared checking and bus tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge CLOCK);
    penable <= 1'b1;
    do @(posedge CLOCK); while (pready !== 1'b1); // Master assumes no wait count
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge CLOCK);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask

  // Expected translation, worked independently from the loaded table
  function automatic logic [7:0] lin(input logic [7:0] c);
    int i;
    int w;
    int v;
    i = int'(c >> atl_pkg::IDX_SHIFT) & 31;
    w = int'(c) & 7;
    v = int'(tbl[i]) + (w * (int'(tbl[i + 1]) - int'(tbl[i]))) / atl_pkg::WGT_DIV;
    return (w == 0) ? tbl[i] : v[7:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset;
    logic [31:0] q;
    logic e;
    chk({14'h0, res}, 32'h0);
    chk({30'h0, g_hi, g_lo}, 32'h0);
    rd(atl_pkg::ADDR_STATUS, 32'h0);
    apb(1'b0, 8'h1c, 32'h0, q, e);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask

  // Other bits set around bit 3 expose a wrong bit position
  task t_gain;
    for (int g = 0; g < 4; g++)
    begin
      wr(atl_pkg::ADDR_PIN_HI, (g & 2) ? 32'h08 : 32'hf7);
      wr(atl_pkg::ADDR_PIN_LO, (g & 1) ? 32'h08 : 32'hf7);
      chk({30'h0, g_hi, g_lo}, 32'(g));
      @(posedge CLOCK); // Result gain field is registered a clock behind the pins
      chk({30'h0, res[17:16]}, 32'(g));
    end
    wr(atl_pkg::ADDR_PIN_HI, 32'h0);
    wr(atl_pkg::ADDR_PIN_LO, 32'h0);
  endtask

  // Wrapping values give falling steps; no measured code lands on one
  task t_load;
    wr(atl_pkg::ADDR_TBL_IDX, 32'h0);
    for (int k = 0; k < 33; k++)
    begin
      tbl[k] = 8'(k * 37 + 5);
      wr(atl_pkg::ADDR_TBL_DATA, {24'h0, tbl[k]});
    end
    rd(atl_pkg::ADDR_TBL_DATA, 32'h0);
  endtask

  // One measurement; mn is the least start delay when the gain must move
  task meas(input logic [7:0] lv, input logic [3:0] d, input logic [1:0] g,
    input logic [7:0] c, input int mn);
    logic [17:0] exp;
    int n;
    int st;
    exp = {g, c, lin(c)};
    level <= lv;
    dly <= d;
    wr(atl_pkg::ADDR_CTRL, 32'h1);
    n = 0;
    st = -1;
    while (valid !== 1'b1 && n < 300)
    begin
      if (conv_start === 1'b1 && st < 0)
        st = n;
      @(posedge CLOCK);
      n++;
    end
    chk({31'h0, valid}, 32'h1);
    chk({31'h0, st >= mn}, 32'h1);
    chk({14'h0, res}, {14'h0, exp});
    chk({30'h0, g_hi, g_lo}, {30'h0, g});
    @(posedge CLOCK);
    rd(atl_pkg::ADDR_RESULT, {14'h0, exp});
    rd(atl_pkg::ADDR_STATUS, 32'h2);
    wr(atl_pkg::ADDR_STATUS, 32'h2);
    rd(atl_pkg::ADDR_STATUS, 32'h0);
  endtask

  task results;
    $display("bad_count=%0d compares=%0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; gain carries over from one measurement to the next
  initial
  begin
    RST_B = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    level = 8'h80;
    dly = 4'h1;
    bad_count = 0;
    compares = 0;
    repeat (6) @(posedge CLOCK);
    RST_B <= 1'b1;
    @(posedge CLOCK);
    t_reset;
    t_gain;
    t_load;
    meas(8'h62, 4'h1, 2'h0, 8'h62, 0);
    meas(8'h80, 4'h6, 2'h0, 8'h80, 0);
    meas(8'h40, 4'h1, 2'h0, 8'h40, 0);
    meas(8'hc7, 4'h2, 2'h0, 8'hc7, 0);
    meas(8'hf9, 4'h1, 2'h0, 8'hf9, 0);
    meas(8'hff, 4'h3, 2'h0, 8'hff, 0);
    meas(8'h30, 4'h1, 2'h1, 8'h60, 5);
    meas(8'h08, 4'h4, 2'h2, 8'h20, 5);
    meas(8'h10, 4'h1, 2'h2, 8'h40, 0);
    meas(8'hff, 4'h2, 2'h1, 8'hff, 5);
    wr(atl_pkg::ADDR_PIN_HI, 32'h08);
    wr(atl_pkg::ADDR_PIN_LO, 32'h08);
    meas(8'h30, 4'h1, 2'h2, 8'hc0, 5);
    wr(atl_pkg::ADDR_PIN_LO, 32'h08);
    meas(8'h04, 4'h1, 2'h3, 8'h20, 0);
    results;
  end
endmodule
